// ==== hdl/msc_pkg.sv ====
// Purpose: Constants and types of the maintenance statistics counters
// Assumes: 25 MHz system clock, AXI4-Lite register access
// Notes:   Counts and offsets shared by the design files
`default_nettype none
package msc_pkg;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam longint unsigned CLK_HZ   = 25_000_000;
  localparam longint unsigned HOUR_S   = 3600;
  localparam longint unsigned HOUR_CYC = CLK_HZ * HOUR_S;
  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] A_PEAK   = 8'h00;
  localparam logic [7:0] A_CAP    = 8'h04;
  localparam logic [7:0] A_BCAP   = 8'h08;
  localparam logic [7:0] A_FAN    = 8'h0c;
  localparam logic [7:0] A_START  = 8'h10;
  localparam logic [7:0] A_ENERGY = 8'h14;
  localparam logic [7:0] A_SCALED = 8'h18;
  localparam logic [7:0] A_ERRCNT = 8'h1c;
  localparam logic [7:0] A_ERRCOD = 8'h20;
  localparam logic [7:0] A_FWVER  = 8'h24;
  localparam logic [7:0] A_MOTHR  = 8'h28;
  localparam logic [7:0] A_REMTIM = 8'h2c;
  localparam logic [7:0] A_REMST  = 8'h30;
  localparam logic [7:0] A_COEF   = 8'h34;
  localparam logic [7:0] A_INTVL  = 8'h38;
  localparam logic [7:0] A_SLIM   = 8'h3c;
  localparam logic [7:0] A_CTRL   = 8'h40;
  localparam logic [7:0] A_IRQST  = 8'h44;
  localparam logic [7:0] A_IRQMSK = 8'h48;
  // ----------------------------------------------------------------
  // Limits and reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] DISP_SPLIT  = 16'h2710;    // 10000
  localparam logic [15:0] TENS_MAX    = 16'h270f;    // 9999
  localparam logic [15:0] ERR_MAX     = 16'h270f;    // 9999
  localparam logic [3:0]  SUB_LAST    = 4'h9;
  localparam logic [15:0] DIV_TEN     = 16'h000a;
  localparam logic [23:0] ENERGY_MAX  = 24'h989298;  // 9999.000
  localparam logic [26:0] SCALED_MAX  = 27'h5f5b9f0; // 9999.0000
  localparam logic [23:0] COEF_RST    = 24'h0003e8;  // 1.000
  localparam logic [15:0] INTVL_RST   = 16'hffff;
  localparam logic [15:0] SLIM_RST    = 16'hffff;
  localparam logic [1:0]  RESP_OK     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;
  // ----------------------------------------------------------------
  // Interrupt bits
  // ----------------------------------------------------------------
  localparam int IRQ_W    = 4;
  localparam int IRQ_ERR  = 0;
  localparam int IRQ_WRAP = 1;
  localparam int IRQ_DUE  = 2;
  localparam int IRQ_HOUR = 3;
  typedef logic [IRQ_W-1:0] msc_irq_t;
endpackage : msc_pkg
`default_nettype wire

// ==== hdl/msc_hour_tick.sv ====
// Purpose: One-hour tick from the system clock
// Assumes: CYC_PER_HOUR at least 2
// Notes:   Tick is a one-cycle pulse
`default_nettype none
module msc_hour_tick #(
  parameter longint unsigned CYC_PER_HOUR = msc_pkg::HOUR_CYC
) (
  // Clock and reset
  input  wire logic CLK,
  input  wire logic RESETN,
  // Tick
  output var  logic TICK
);
  logic [39:0] cnt_q;
  logic [39:0] cnt_d;
  logic        tick_d;

  always_comb begin
    tick_d = (cnt_q == 40'(CYC_PER_HOUR - 1));
    cnt_d  = tick_d ? 40'h0 : cnt_q + 40'h1;
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      cnt_q <= 40'h0;
      TICK  <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      TICK  <= tick_d;
    end
  end
endmodule // msc_hour_tick
`default_nettype wire

// ==== hdl/msc_top.sv ====
// Purpose: Maintenance statistics counters behind an AXI4-Lite slave
// Assumes: Event inputs are one-cycle pulses synchronous to CLK
// Notes:   Run-time counts advance on the hourly tick
//
// The register addresses and register access over AXI4-Lite were left to the implementer.
`default_nettype none
module msc_top
  import msc_pkg::*;
#(
  parameter longint unsigned CYC_PER_HOUR = msc_pkg::HOUR_CYC,
  parameter logic [15:0]     FW_VERSION   = 16'h0001  // Arbitrary value
) (
  // Clock and reset
  input  wire logic        CLK,
  input  wire logic        RESETN,
  // AXI4-Lite write
  input  wire logic        S_AXI_AWVALID,
  output var  logic        S_AXI_AWREADY,
  input  wire logic [7:0]  S_AXI_AWADDR,
  input  wire logic        S_AXI_WVALID,
  output var  logic        S_AXI_WREADY,
  input  wire logic [31:0] S_AXI_WDATA,
  input  wire logic [3:0]  S_AXI_WSTRB,
  output var  logic        S_AXI_BVALID,
  input  wire logic        S_AXI_BREADY,
  output var  logic [1:0]  S_AXI_BRESP,
  // AXI4-Lite read
  input  wire logic        S_AXI_ARVALID,
  output var  logic        S_AXI_ARREADY,
  input  wire logic [7:0]  S_AXI_ARADDR,
  output var  logic        S_AXI_RVALID,
  input  wire logic        S_AXI_RREADY,
  output var  logic [31:0] S_AXI_RDATA,
  output var  logic [1:0]  S_AXI_RRESP,
  // Measurements
  input  wire logic [15:0] CUR_AMPS,
  input  wire logic [7:0]  CAP_PERCENT,
  input  wire logic        VOLT_APPLIED,
  input  wire logic        FAN_RUNNING,
  input  wire logic        MOTOR_RUNNING,
  input  wire logic        RUN_CMD,
  input  wire logic        ENERGY_PULSE,
  // Serial link and keypad
  input  wire logic        COMM_ERR,
  input  wire logic [15:0] COMM_ERR_CODE,
  input  wire logic        KEYPAD_PRESENT,
  input  wire logic [15:0] KEYPAD_VERSION,
  // Interrupt
  output var  logic        IRQ
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        awrdy;
    logic        wrdy;
    logic        aw_have;
    logic        w_have;
    logic [7:0]  awaddr;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arrdy;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic [15:0] peak;
    logic [15:0] run_max;
    logic [7:0]  cap_pct;
    logic [15:0] bcap_tens;
    logic [3:0]  bcap_sub;
    logic [15:0] fan_tens;
    logic [3:0]  fan_sub;
    logic [15:0] starts;
    logic [15:0] mot_hours;
    logic [23:0] energy;
    logic [26:0] scaled;
    logic [15:0] err_cnt;
    logic [15:0] err_code;
    logic [15:0] rem_time;
    logic [15:0] rem_starts;
    logic [23:0] coef;
    logic [15:0] interval;
    logic [15:0] slimit;
    logic        fan_ctl;
    msc_irq_t    irq_st;
    msc_irq_t    irq_mask;
    logic        irq;
  } msc_state_s;

  msc_state_s s_q;
  msc_state_s s_d;
  logic       hour_tick;
  logic       wr_fire;
  logic       coef_zero_wr;
  logic [15:0] pk_next;

  msc_hour_tick #(
    .CYC_PER_HOUR (CYC_PER_HOUR)
  ) u_tick (
    .CLK    (CLK),
    .RESETN (RESETN),
    .TICK   (hour_tick)
  );

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Unit steps below 10000, steps of ten above
  function automatic logic [15:0] disp_fmt(input logic [15:0] v);
    disp_fmt = (v < DISP_SPLIT) ? v : v / DIV_TEN;
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0]  be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) r[8*i +: 8] = nw[8*i +: 8];
    end
    merge = r;
  endfunction

  function automatic logic [15:0] sub_clamp(input logic [15:0] a,
                                            input logic [15:0] b);
    sub_clamp = (a > b) ? a - b : 16'h0;
  endfunction

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [31:0] wv;
    logic [15:0] rt;
    logic [26:0] sc;
    logic        rd_ok;
    msc_irq_t    ev;
    wv    = 32'h0;
    rt    = 16'h0;
    sc    = 27'h0;
    rd_ok = 1'b1;
    ev    = '0;
    s_d   = s_q;

    // Write channel: address and data in either order
    if (S_AXI_AWVALID && s_q.awrdy) begin
      s_d.aw_have = 1'b1;
      s_d.awaddr  = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID && s_q.wrdy) begin
      s_d.w_have = 1'b1;
      s_d.wdata  = S_AXI_WDATA;
      s_d.wstrb  = S_AXI_WSTRB;
    end
    if (s_q.bvalid && S_AXI_BREADY) s_d.bvalid = 1'b0;
    wr_fire      = s_q.aw_have && s_q.w_have && !s_q.bvalid;
    coef_zero_wr = 1'b0;

    // Peak current per hour
    pk_next = (CUR_AMPS > s_q.run_max) ? CUR_AMPS : s_q.run_max;
    if (hour_tick) begin
      s_d.peak    = pk_next;
      s_d.run_max = CUR_AMPS;
    end else begin
      s_d.run_max = pk_next;
    end
    s_d.cap_pct = CAP_PERCENT;

    // Ten-hour accumulators and the hourly motor count
    if (hour_tick && VOLT_APPLIED && s_q.bcap_tens != TENS_MAX) begin
      if (s_q.bcap_sub == SUB_LAST) begin
        s_d.bcap_sub  = 4'h0;
        s_d.bcap_tens = s_q.bcap_tens + 16'h1;
      end else begin
        s_d.bcap_sub = s_q.bcap_sub + 4'h1;
      end
    end
    if (hour_tick && (FAN_RUNNING || !s_q.fan_ctl) &&
        s_q.fan_tens != TENS_MAX) begin
      if (s_q.fan_sub == SUB_LAST) begin
        s_d.fan_sub  = 4'h0;
        s_d.fan_tens = s_q.fan_tens + 16'h1;
      end else begin
        s_d.fan_sub = s_q.fan_sub + 4'h1;
      end
    end
    if (hour_tick && MOTOR_RUNNING)
      s_d.mot_hours = s_q.mot_hours + 16'h1;

    // Startups wrap naturally at 16 bits
    if (RUN_CMD) begin
      s_d.starts = s_q.starts + 16'h1;
      if (s_q.starts == 16'hffff) ev[IRQ_WRAP] = 1'b1;
    end

    // Energy in 0.1 kWh, scaled in units of 0.0001
    if (ENERGY_PULSE) begin
      if (s_q.energy != ENERGY_MAX)
        s_d.energy = s_q.energy + 24'h1;
      sc = s_q.scaled + {3'h0, s_q.coef};
      if (sc > SCALED_MAX || sc < s_q.scaled)
        s_d.scaled = SCALED_MAX;
      else
        s_d.scaled = sc;
    end

    // Serial link errors
    if (COMM_ERR) begin
      s_d.err_cnt  = (s_q.err_cnt >= ERR_MAX) ? 16'h0
                                              : s_q.err_cnt + 16'h1;
      s_d.err_code = COMM_ERR_CODE;
      ev[IRQ_ERR]  = 1'b1;
    end

    // Register writes
    if (wr_fire) begin
      s_d.aw_have = 1'b0;
      s_d.w_have  = 1'b0;
      s_d.bvalid  = 1'b1;
      s_d.bresp   = RESP_OK;
      unique case (s_q.awaddr)
        A_COEF: begin
          wv = merge({8'h0, s_q.coef}, s_q.wdata, s_q.wstrb);
          s_d.coef = wv[23:0];
          if (wv[23:0] == 24'h0) begin
            coef_zero_wr = 1'b1;
            s_d.energy   = 24'h0;
            s_d.scaled   = 27'h0;
          end
        end
        A_INTVL: begin
          wv = merge({16'h0, s_q.interval}, s_q.wdata, s_q.wstrb);
          s_d.interval = wv[15:0];
        end
        A_SLIM: begin
          wv = merge({16'h0, s_q.slimit}, s_q.wdata, s_q.wstrb);
          s_d.slimit = wv[15:0];
        end
        A_CTRL: begin
          if (s_q.wstrb[0]) s_d.fan_ctl = s_q.wdata[0];
        end
        A_IRQMSK: begin
          if (s_q.wstrb[0]) s_d.irq_mask = s_q.wdata[IRQ_W-1:0];
        end
        A_PEAK, A_CAP, A_BCAP, A_FAN, A_START, A_ENERGY, A_SCALED,
        A_ERRCNT, A_ERRCOD, A_FWVER, A_MOTHR, A_REMTIM, A_REMST,
        A_IRQST: ;
        default: s_d.bresp = RESP_SLVERR;
      endcase
    end
    s_d.awrdy = !s_d.aw_have && !s_d.bvalid;
    s_d.wrdy  = !s_d.w_have && !s_d.bvalid;

    // Maintenance estimates
    rt = sub_clamp(s_q.interval, s_q.mot_hours) / DIV_TEN;
    s_d.rem_time   = (rt > TENS_MAX) ? TENS_MAX : rt;
    s_d.rem_starts = sub_clamp(s_q.slimit, s_q.starts);
    if (s_d.rem_time == 16'h0 && s_q.rem_time != 16'h0)
      ev[IRQ_DUE] = 1'b1;
    ev[IRQ_HOUR] = hour_tick;

    // Register reads
    if (s_q.rvalid && S_AXI_RREADY) s_d.rvalid = 1'b0;
    if (S_AXI_ARVALID && s_q.arrdy) begin
      s_d.rvalid = 1'b1;
      s_d.rdata  = 32'h0;
      unique case (S_AXI_ARADDR)
        A_PEAK:   s_d.rdata = {16'h0, s_q.peak};
        A_CAP:    s_d.rdata = {24'h0, s_q.cap_pct};
        A_BCAP:   s_d.rdata = {16'h0, s_q.bcap_tens};
        A_FAN:    s_d.rdata = {16'h0, s_q.fan_tens};
        A_START:  s_d.rdata = {disp_fmt(s_q.starts), s_q.starts};
        A_ENERGY: s_d.rdata = {8'h0, s_q.energy};
        A_SCALED: s_d.rdata = {5'h0, s_q.scaled};
        A_ERRCNT: s_d.rdata = {16'h0, s_q.err_cnt};
        A_ERRCOD: s_d.rdata = {16'h0, s_q.err_code};
        A_FWVER:  s_d.rdata = {KEYPAD_PRESENT ? KEYPAD_VERSION : 16'h0,
                               FW_VERSION};
        A_MOTHR:  s_d.rdata = {disp_fmt(s_q.mot_hours),
                               s_q.mot_hours};
        A_REMTIM: s_d.rdata = {16'h0, s_q.rem_time};
        A_REMST:  s_d.rdata = {disp_fmt(s_q.rem_starts),
                               s_q.rem_starts};
        A_COEF:   s_d.rdata = {8'h0, s_q.coef};
        A_INTVL:  s_d.rdata = {16'h0, s_q.interval};
        A_SLIM:   s_d.rdata = {16'h0, s_q.slimit};
        A_CTRL:   s_d.rdata = {31'h0, s_q.fan_ctl};
        A_IRQST:  s_d.rdata = {28'h0, s_q.irq_st};
        A_IRQMSK: s_d.rdata = {28'h0, s_q.irq_mask};
        default:  rd_ok = 1'b0;
      endcase
      s_d.rresp = rd_ok ? RESP_OK : RESP_SLVERR;
      if (S_AXI_ARADDR == A_IRQST) s_d.irq_st = '0;
    end
    s_d.arrdy = !s_d.rvalid;

    // Sticky events win over the read clear
    s_d.irq_st = s_d.irq_st | ev;
    s_d.irq    = |(s_d.irq_st & s_d.irq_mask);
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      s_q          <= '0;
      s_q.awrdy    <= 1'b1;
      s_q.wrdy     <= 1'b1;
      s_q.arrdy    <= 1'b1;
      s_q.coef     <= COEF_RST;
      s_q.interval <= INTVL_RST;
      s_q.slimit   <= SLIM_RST;
      s_q.rem_time <= TENS_MAX;
    end else begin
      s_q <= s_d;
    end
  end

  assign S_AXI_AWREADY = s_q.awrdy;
  assign S_AXI_WREADY  = s_q.wrdy;
  assign S_AXI_BVALID  = s_q.bvalid;
  assign S_AXI_BRESP   = s_q.bresp;
  assign S_AXI_ARREADY = s_q.arrdy;
  assign S_AXI_RVALID  = s_q.rvalid;
  assign S_AXI_RDATA   = s_q.rdata;
  assign S_AXI_RRESP   = s_q.rresp;
  assign IRQ           = s_q.irq;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESETN);

  sequence coef_zero_s;
    wr_fire && coef_zero_wr;
  endsequence
  sequence energy_cleared_s;
    s_q.energy == 24'h0 && s_q.scaled == 27'h0 && s_q.coef == 24'h0;
  endsequence

  peak_reload_a: assert property (
    hour_tick |=> s_q.peak == $past(pk_next) &&
                  s_q.run_max == $past(CUR_AMPS))
    else $error("peak not reloaded at hour tick");
  cap_follow_a: assert property (
    RESETN |=> s_q.cap_pct == $past(CAP_PERCENT))
    else $error("capacitor percent not tracked");
  bcap_hold_a: assert property (
    s_q.bcap_tens == TENS_MAX |=> s_q.bcap_tens == TENS_MAX)
    else $error("board capacitor count left saturation");
  fan_gate_a: assert property (
    (hour_tick && s_q.fan_ctl && !FAN_RUNNING) |=>
      $stable(s_q.fan_tens) && $stable(s_q.fan_sub))
    else $error("fan hours advanced while stopped");
  start_inc_a: assert property (
    RUN_CMD |=> s_q.starts == 16'($past(s_q.starts) + 16'h1))
    else $error("startup count not incremented");
  scaled_clamp_a: assert property (
    s_q.scaled <= SCALED_MAX)
    else $error("scaled energy above limit");
  coef_clear_a: assert property (
    coef_zero_s |=> energy_cleared_s)
    else $error("zero coefficient did not clear energy");
  err_wrap_a: assert property (
    (COMM_ERR && s_q.err_cnt == ERR_MAX) |=> s_q.err_cnt == 16'h0)
    else $error("error counter did not return to zero");
  err_code_a: assert property (
    COMM_ERR |=> s_q.err_code == $past(COMM_ERR_CODE))
    else $error("latest error code not kept");
  rem_clamp_a: assert property (
    (s_q.mot_hours >= s_q.interval) |=> s_q.rem_time == 16'h0)
    else $error("remaining time not clamped at zero");
  irq_level_a: assert property (
    IRQ == |(s_q.irq_st & s_q.irq_mask))
    else $error("interrupt level mismatch");
  err_sticky_a: assert property (
    COMM_ERR |=> s_q.irq_st[IRQ_ERR])
    else $error("error status bit not set");
endmodule // msc_top
`default_nettype wire

// ==== bench/msc_top_tb.sv ====
// Purpose: Self-checking bench of the maintenance statistics counters
// Assumes: Hour shortened to 20 cycles, bus driven at the rising edge
// Notes:   Hour ticks are found by polling the sticky hour status bit
`default_nettype none
module msc_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import msc_pkg::*;
  // ------------------------------------------------------------
  // Stimulus and design
  // ------------------------------------------------------------
  logic        clk   = '0;
  logic        rst_n = '0;
  logic        awv   = '0;
  logic        wv    = '0;
  logic        bry   = '0;
  logic        arv   = '0;
  logic        rry   = '0;
  logic [7:0]  awa   = '0;
  logic [7:0]  ara   = '0;
  logic [31:0] wd    = '0;
  logic [3:0]  ws    = 4'hf;
  logic        volt  = '0;
  logic        fan   = '0;
  logic        mot   = '0;
  logic        kp    = '0;
  logic [2:0]  evs   = '0;
  logic [15:0] cur   = 16'h004d;
  logic [15:0] code  = '0;
  logic [15:0] kver  = 16'h1234;
  logic [7:0]  capp  = 8'h64;
  wire logic        awr, wr, bv, arr, rv, irq;
  wire logic [1:0]  br, rr;
  wire logic [31:0] rd;
  int n_fail       = 0;
  int total_checks = 0;

  // Version value is arbitrary
  msc_top #(.CYC_PER_HOUR(20), .FW_VERSION(16'h0a5c)) i_dut (
    .CLK(clk), .RESETN(rst_n), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr),
    .S_AXI_AWADDR(awa), .S_AXI_WVALID(wv), .S_AXI_WREADY(wr),
    .S_AXI_WDATA(wd), .S_AXI_WSTRB(ws), .S_AXI_BVALID(bv),
    .S_AXI_BREADY(bry), .S_AXI_BRESP(br), .S_AXI_ARVALID(arv),
    .S_AXI_ARREADY(arr), .S_AXI_ARADDR(ara), .S_AXI_RVALID(rv),
    .S_AXI_RREADY(rry), .S_AXI_RDATA(rd), .S_AXI_RRESP(rr),
    .CUR_AMPS(cur), .CAP_PERCENT(capp), .VOLT_APPLIED(volt),
    .FAN_RUNNING(fan), .MOTOR_RUNNING(mot), .RUN_CMD(evs[0]),
    .ENERGY_PULSE(evs[2]), .COMM_ERR(evs[1]), .COMM_ERR_CODE(code),
    .KEYPAD_PRESENT(kp), .KEYPAD_VERSION(kver), .IRQ(irq));

  always #20 clk = ~clk;
  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e,
                     input string m);
    total_checks++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask

  task automatic tmo();
    n_fail++;
    $display("CHECK FAILED %0t bus wait ran out", $time);
    stop_test();
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                        output logic [1:0] r);
    int   n;
    logic pa, pw, done;
    n = 0;
    pa = 1'h1;
    pw = 1'h1;
    done = 1'h0;
    @(posedge clk);
    awv <= 1'h1;
    wv <= 1'h1;
    awa <= a;
    wd <= d;
    bry <= 1'h1;
    while (!done && n < 100) begin
      @(posedge clk);
      n++;
      if (awr) pa = 1'h0;
      if (wr) pw = 1'h0;
      awv <= pa;
      wv <= pw;
      done = bv;
      r = br;
    end
    bry <= 1'h0;
    if (!done) tmo();
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
                        output logic [1:0] r);
    int   n;
    logic p, done;
    n = 0;
    p = 1'h1;
    done = 1'h0;
    @(posedge clk);
    arv <= 1'h1;
    ara <= a;
    rry <= 1'h1;
    while (!done && n < 100) begin
      @(posedge clk);
      n++;
      if (arr) p = 1'h0;
      arv <= p;
      done = rv;
      d = rd;
      r = rr;
    end
    rry <= 1'h0;
    if (!done) tmo();
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0]  r;
    axi_rd(a, d, r);
    chk(d, e, $sformatf("data at %h", a));
    chk({30'h0, r}, {30'h0, RESP_OK}, "read response");
  endtask

  task automatic wrc(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    axi_wr(a, d, r);
    chk({30'h0, r}, {30'h0, RESP_OK}, "write response");
  endtask

  // Event inputs held high for n cycles give n events
  task automatic ev(input logic [2:0] k, input int n);
    @(posedge clk);
    evs <= k;
    repeat (n) @(posedge clk);
    evs <= 3'h0;
  endtask

  task automatic wait_hr();
    logic [31:0] d;
    logic [1:0]  r;
    int          i;
    for (i = 0; i < 50; i++) begin
      axi_rd(A_IRQST, d, r);
      if (d[IRQ_HOUR]) break;
    end
    if (i == 50) tmo();
  endtask
  // ------------------------------------------------------------
  // Sequence
  // ------------------------------------------------------------
  initial begin
    logic [31:0] d;
    logic [1:0]  r;
    repeat (2) @(posedge clk);
    rst_n <= 1'h1;
    rdc(A_COEF, 32'h3e8);
    rdc(A_INTVL, 32'hffff);
    rdc(A_SLIM, 32'hffff);
    rdc(A_ERRCNT, 32'h0);
    axi_wr(8'h4c, 32'h1, r);
    chk({30'h0, r}, {30'h0, RESP_SLVERR}, "unmapped write");
    axi_rd(8'h4c, d, r);
    chk(d, 32'h0, "unmapped read data");
    chk({30'h0, r}, {30'h0, RESP_SLVERR}, "unmapped read");
    rdc(A_FWVER, 32'h00000a5c);
    kp <= 1'h1;
    rdc(A_FWVER, 32'h12340a5c);
    rdc(A_CAP, 32'h64);
    wrc(A_CTRL, 32'h1);
    repeat (2) wait_hr();
    volt <= 1'h1;
    fan <= 1'h1;
    mot <= 1'h1;
    repeat (10) wait_hr();
    volt <= 1'h0;
    fan <= 1'h0;
    mot <= 1'h0;
    repeat (10) wait_hr();
    rdc(A_BCAP, 32'h1);
    rdc(A_FAN, 32'h1);
    rdc(A_MOTHR, 32'h000a000a);
    rdc(A_PEAK, 32'h4d);
    cur <= 16'h0005;
    repeat (2) wait_hr();
    rdc(A_PEAK, 32'h5);
    wrc(A_INTVL, 32'h19);
    rdc(A_REMTIM, 32'h1);
    wrc(A_INTVL, 32'h5);
    rdc(A_REMTIM, 32'h0);
    wrc(A_INTVL, 32'hffff);
    rdc(A_REMTIM, 32'h1998);
    ev(3'h1, 3);
    rdc(A_START, 32'h00030003);
    wrc(A_SLIM, 32'h2);
    rdc(A_REMST, 32'h0);
    wrc(A_SLIM, 32'ha);
    rdc(A_REMST, 32'h00070007);
    ev(3'h1, 9997);
    rdc(A_START, 32'h03e82710);
    axi_rd(A_IRQST, d, r);
    ev(3'h1, 55538);
    rdc(A_START, 32'h00020002);
    axi_rd(A_IRQST, d, r);
    chk(d & 32'h2, 32'h2, "wrap flag");
    ev(3'h4, 5);
    rdc(A_ENERGY, 32'h5);
    rdc(A_SCALED, 32'h1388);
    wrc(A_COEF, 32'h989298);
    ev(3'h4, 11);
    rdc(A_ENERGY, 32'h10);
    rdc(A_SCALED, 32'h5f5b9f0);
    wrc(A_COEF, 32'h0);
    rdc(A_ENERGY, 32'h0);
    rdc(A_SCALED, 32'h0);
    axi_rd(A_IRQST, d, r);
    wrc(A_IRQMSK, 32'h1);
    chk({31'h0, irq}, 32'h0, "irq idle");
    for (int i = 0; i < 3; i++) begin
      code <= 16'h000b + 16'(i);
      ev(3'h2, 1);
    end
    rdc(A_ERRCNT, 32'h3);
    rdc(A_ERRCOD, 32'hd);
    chk({31'h0, irq}, 32'h1, "irq raised");
    axi_rd(A_IRQST, d, r);
    chk(d & 32'h1, 32'h1, "error flag");
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h0, "irq cleared");
    wrc(A_IRQMSK, 32'h0);
    ev(3'h2, 9997);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h0, "irq masked");
    rdc(A_ERRCNT, 32'h0);
    ws <= 4'h1;
    wrc(A_INTVL, 32'h0000aa77);
    ws <= 4'hf;
    rdc(A_INTVL, 32'hff77);
    stop_test();
  end
endmodule // msc_top_tb
`default_nettype wire
